//--- rtl/acs_defs.vh
// Constants for the ASCII checksum checker and shed watchdog
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// Framing characters
`define ACS_CHAR_CR      8'h0D
`define ACS_CHAR_LF      8'h0A
// Seven data bits carry the code; the top bit is parity
`define ACS_PARITY_MASK  8'h7F
// Characters in the checksum field
`define ACS_CS_DIGITS    2'h2
// Hex digit alphabet, upper case only
`define ACS_CHAR_ZERO    8'h30
`define ACS_CHAR_NINE    8'h39
`define ACS_CHAR_UPA     8'h41
`define ACS_CHAR_UPF     8'h46
`define ACS_ALPHA_BIAS   8'h37
// Request status characters
`define ACS_STAT_OK_HI   8'h30
`define ACS_STAT_OK_LO   8'h30
`define ACS_STAT_CS_HI   8'h30
`define ACS_STAT_CS_LO   8'h34
// Device status high digit
`define ACS_DEV_OK_HI    8'h30
`define ACS_DEV_SHED_HI  8'h38
// Shed time in sample periods of one third of a second
`define ACS_SHED_OFF     8'h00
`define ACS_SHED_MAX     8'hF9
// Count left when the next tick expires the watchdog, and one step
`define ACS_SHED_LAST    8'h01
`define ACS_SHED_STEP    8'h01
// Reset values
`define ACS_RST_CHAR     8'h30
`define ACS_RST_BYTE     8'h00
`define ACS_RST_MODE     2'h0

`endif

//--- rtl/acs_checksum_shed.v
// ASCII request checksum checker, response checksum and shed watchdog
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"

module acs_checksum_shed (
    input  wire       core_clk,
    input  wire       reset_n,
    // Request character stream
    input  wire       rxValid,
    input  wire [7:0] rxChar,
    input  wire       rxParityErr,
    input  wire       reqProtected,
    input  wire       reqHostCtl,
    // Request result
    output reg        reqDone,
    output reg        reqAccept,
    output reg        reqDiscard,
    output reg  [7:0] reqStatHi,
    output reg  [7:0] reqStatLo,
    output reg  [7:0] devStatHi,
    output reg  [7:0] devStatLo,
    // Device fault code, zero when healthy
    input  wire [2:0] devFaultCode,
    // Response character stream
    input  wire       respStart,
    input  wire       respValid,
    input  wire [7:0] respChar,
    output reg  [7:0] respCsHi,
    output reg  [7:0] respCsLo,
    output reg        respCsAppend,
    // Shed watchdog
    input  wire       sampleTick,
    input  wire [7:0] shedTimeCfg,
    input  wire [1:0] shedModeCfg,
    input  wire [7:0] shedLevelCfg,
    input  wire [1:0] shedSpCfg,
    output reg        hostMode,
    output reg        shedEvent,
    output reg  [1:0] localMode,
    output reg  [7:0] localLevel,
    output reg  [1:0] setpointSel,
    output reg  [7:0] shedCount
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Nibble to upper-case ASCII hex digit
    // Only digits and capitals are produced, matching what hexDec accepts
    function [7:0] hexEnc;
        input [3:0] nib;
        begin
            if (nib < 4'hA) begin
                hexEnc = `ACS_CHAR_ZERO + {4'h0, nib};
            end else begin
                hexEnc = `ACS_ALPHA_BIAS + {4'h0, nib};
            end
        end
    endfunction

    // ASCII hex digit to nibble; bit 4 flags a non-hex character
    // Lower-case digits are refused, so a host that sends them gets 04
    function [4:0] hexDec;
        input [7:0] ch;
        reg   [7:0] t;
        begin
            t = 8'h00;
            if (ch >= `ACS_CHAR_ZERO && ch <= `ACS_CHAR_NINE) begin
                t = ch - `ACS_CHAR_ZERO;
                hexDec = {1'b0, t[3:0]};
            end else if (ch >= `ACS_CHAR_UPA && ch <= `ACS_CHAR_UPF) begin
                t = ch - `ACS_ALPHA_BIAS;
                hexDec = {1'b0, t[3:0]};
            end else begin
                hexDec = 5'h10;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Request accumulation

    // Request side state; all of it but shedFlag_reg clears when CR ends a message
    reg  [7:0] sumAll_reg;
    reg  [7:0] last1_reg;
    reg  [7:0] last2_reg;
    reg  [1:0] seen_reg;
    reg        parErr_reg;
    reg        shedFlag_reg;

    // CR and LF are framing only and never enter the sum
    wire [7:0] rxMasked = rxChar & `ACS_PARITY_MASK;
    wire       rxIsCr   = (rxMasked == `ACS_CHAR_CR);
    wire       rxIsLf   = (rxMasked == `ACS_CHAR_LF);
    wire       rxData   = rxValid && !rxIsCr && !rxIsLf;
    wire       rxEnd    = rxValid && rxIsCr;

    // Running sum, two-character window and sticky parity fault.
    // The last two characters are only known to be the checksum once CR
    // arrives, so they are kept apart and removed from the total then.
    // LF after CR is dropped unseen, so its parity cannot spoil the
    // request that follows it.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sumAll_reg <= `ACS_RST_BYTE;
            last1_reg  <= `ACS_RST_BYTE;
            last2_reg  <= `ACS_RST_BYTE;
            seen_reg   <= 2'h0;
            parErr_reg <= 1'b0;
        end else if (rxEnd) begin
            sumAll_reg <= `ACS_RST_BYTE;
            last1_reg  <= `ACS_RST_BYTE;
            last2_reg  <= `ACS_RST_BYTE;
            seen_reg   <= 2'h0;
            parErr_reg <= 1'b0;
        end else if (rxData) begin
            sumAll_reg <= sumAll_reg + rxMasked;
            last1_reg  <= rxMasked;
            last2_reg  <= last1_reg;
            if (seen_reg != `ACS_CS_DIGITS) begin
                seen_reg <= seen_reg + 2'h1;
            end
            if (rxParityErr) begin
                parErr_reg <= 1'b1;
            end
        end
    end

    // Check at CR: parity of CR itself also counts
    // Limitation: a protected request with fewer than two characters
    // before CR has no field and is always refused with 04.
    wire [7:0] sumBody  = sumAll_reg - last1_reg - last2_reg;
    wire [4:0] decHi    = hexDec(last2_reg);
    wire [4:0] decLo    = hexDec(last1_reg);
    wire       fieldOk  = (seen_reg == `ACS_CS_DIGITS) &&
                          !decHi[4] && !decLo[4];
    wire       csMatch  = fieldOk &&
                          ({decHi[3:0], decLo[3:0]} == sumBody);
    wire       parBad   = parErr_reg || rxParityErr;
    wire       reqGood  = !parBad && (!reqProtected || csMatch);

    ////////////////////////////////////////////////////////////////////////
    // Request result registers

    // Status characters for the response head, held until next request
    // reqDone marks the one cycle in which a reader should copy them
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reqDone      <= 1'b0;
            reqAccept    <= 1'b0;
            reqDiscard   <= 1'b0;
            reqStatHi    <= `ACS_RST_CHAR;
            reqStatLo    <= `ACS_RST_CHAR;
            devStatHi    <= `ACS_RST_CHAR;
            devStatLo    <= `ACS_RST_CHAR;
            respCsAppend <= 1'b0;
        end else begin
            reqDone <= rxEnd;
            if (rxEnd) begin
                // A refused request gets 04 CR LF only, never a field
                respCsAppend <= reqProtected && reqGood;
                if (reqGood) begin
                    reqAccept  <= 1'b1;
                    reqDiscard <= 1'b0;
                    reqStatHi  <= `ACS_STAT_OK_HI;
                    reqStatLo  <= `ACS_STAT_OK_LO;
                    // Fault code rides under status 00
                    devStatLo  <= hexEnc({1'b0, devFaultCode});
                    devStatHi  <= shedFlag_reg ? `ACS_DEV_SHED_HI
                                               : `ACS_DEV_OK_HI;
                end else begin
                    // Request is dropped; only 04 CR LF goes back
                    // Device status is left alone for the next good reply
                    reqAccept  <= 1'b0;
                    reqDiscard <= 1'b1;
                    reqStatHi  <= `ACS_STAT_CS_HI;
                    reqStatLo  <= `ACS_STAT_CS_LO;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response checksum

    // Response sum runs apart from the request side, so both may overlap
    reg  [7:0] respSum_reg;
    reg  [7:0] respSum_next;
    wire [7:0] respMasked = respChar & `ACS_PARITY_MASK;

    // A character given with respStart is the first of the new message
    // The caller stops feeding before the field itself and before CR LF,
    // so the digits then hold the field of the reply being built.
    always @* begin
        respSum_next = respSum_reg;
        if (respStart) begin
            respSum_next = `ACS_RST_BYTE;
        end
        if (respValid) begin
            respSum_next = respSum_next + respMasked;
        end
    end

    // Digits track the sum so far; caller feeds only pre-checksum chars
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            respSum_reg <= `ACS_RST_BYTE;
            respCsHi    <= `ACS_RST_CHAR;
            respCsLo    <= `ACS_RST_CHAR;
        end else begin
            respSum_reg <= respSum_next;
            respCsHi    <= hexEnc(respSum_next[7:4]);
            respCsLo    <= hexEnc(respSum_next[3:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shed watchdog

    // The countdown runs only under host control; local operation leaves
    // it parked until a host-control message arrives.
    // Any good host-control message restarts the watchdog
    wire       hostReload = rxEnd && reqGood && reqHostCtl;
    // Trade-off: settings above the top of the range are clamped rather
    // than refused, so a mistyped shed time still gives a working
    // watchdog instead of one that never sheds.
    wire [7:0] shedLoad   = (shedTimeCfg > `ACS_SHED_MAX) ? `ACS_SHED_MAX
                                                          : shedTimeCfg;
    wire       shedOn     = (shedLoad != `ACS_SHED_OFF);
    // One countdown step is due on this sample tick
    wire       shedStep   = hostMode && shedOn && sampleTick;
    wire       expire     = shedStep && (shedCount == `ACS_SHED_LAST) &&
                            !hostReload;

    // Reload beats a tick in the same cycle so a fresh message never sheds.
    // Local settings are copied only at the shed, so later changes to them
    // act on the next shed and not on the mode already in force.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hostMode    <= 1'b0;
            shedEvent   <= 1'b0;
            shedCount   <= `ACS_RST_BYTE;
            localMode   <= `ACS_RST_MODE;
            localLevel  <= `ACS_RST_BYTE;
            setpointSel <= `ACS_RST_MODE;
        end else begin
            shedEvent <= expire;
            if (hostReload) begin
                hostMode  <= 1'b1;
                shedCount <= shedLoad;
            end else if (expire) begin
                hostMode    <= 1'b0;
                // Count is parked at zero until the host comes back
                shedCount   <= `ACS_RST_BYTE;
                localMode   <= shedModeCfg;
                localLevel  <= shedLevelCfg;
                setpointSel <= shedSpCfg;
            end else if (shedStep && shedCount != `ACS_SHED_OFF) begin
                shedCount <= shedCount - `ACS_SHED_STEP;
            end
        end
    end

    // Restart-after-shed flag; a shed in the reporting cycle wins
    // A shed in the same cycle as a good request survives, so the
    // restart is still reported by the request after it.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shedFlag_reg <= 1'b0;
        end else if (expire) begin
            shedFlag_reg <= 1'b1;
        end else if (rxEnd && reqGood) begin
            shedFlag_reg <= 1'b0;
        end
    end

endmodule // acs_checksum_shed

`default_nettype wire

//--- verification/acs_checksum_shed_properties.sv
// Checker for request verdicts, response checksum and shed watchdog
`timescale 1ns/1ps
`default_nettype none
module acs_checksum_shed_properties (
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       rxValid,
    input wire logic       rxParityErr,
    input wire logic       reqDone,
    input wire logic       reqAccept,
    input wire logic       reqDiscard,
    input wire logic       respStart,
    input wire logic       respValid,
    input wire logic       respCsAppend,
    input wire logic       sampleTick,
    input wire logic       hostMode,
    input wire logic       shedEvent,
    input wire logic [7:0] rxChar,
    input wire logic [7:0] reqStatHi,
    input wire logic [7:0] reqStatLo,
    input wire logic [7:0] respChar,
    input wire logic [7:0] respCsHi,
    input wire logic [7:0] respCsLo,
    input wire logic [7:0] shedCount,
    input wire logic [7:0] shedTimeCfg,
    input wire logic [7:0] shedLevelCfg,
    input wire logic [7:0] localLevel,
    input wire logic [1:0] shedModeCfg,
    input wire logic [1:0] shedSpCfg,
    input wire logic [1:0] localMode,
    input wire logic [1:0] setpointSel
);
    // Two upper-case hex digits of a byte
    function automatic logic [15:0] hx2(input logic [7:0] v);
        hx2[15:8] = v[7:4] + ((v[7:4] < 4'hA) ? 8'h30 : 8'h37);
        hx2[7:0] = v[3:0] + ((v[3:0] < 4'hA) ? 8'h30 : 8'h37);
    endfunction
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Parity bit is ignored when spotting the end of a request
    wire cr = rxValid && (rxChar[6:0] == 7'h0D);
    // Shedding is live only while a nonzero shed time is configured
    wire shedLive = (shedTimeCfg != 8'h00);
    sequence crIn; cr; endsequence
    sequence okDone; reqDone && reqAccept; endsequence
    sequence dropDone; reqDone && reqDiscard; endsequence
    sequence lastTick;
        hostMode && shedLive && sampleTick && !rxValid && shedCount == 8'h01;
    endsequence
    sequence midTick;
        hostMode && shedLive && sampleTick && !rxValid && shedCount > 8'h01;
    endsequence
    chk_done_after_cr: assert property (crIn |=> reqDone)
        else $error("no verdict after request end");
    chk_done_cause: assert property (reqDone |-> $past(cr))
        else $error("verdict without request end");
    chk_one_verdict: assert property (
        reqDone |-> reqAccept ^ reqDiscard)
        else $error("verdict not exclusive");
    chk_ok_status: assert property (
        okDone |-> reqStatHi == 8'h30 && reqStatLo == 8'h30)
        else $error("good request status wrong");
    chk_fail_status: assert property (
        dropDone |-> reqStatHi == 8'h30 && reqStatLo == 8'h34)
        else $error("discard status wrong");
    chk_parity_drop: assert property (
        cr && rxParityErr |=> reqDiscard)
        else $error("parity fault not discarded");
    chk_drop_no_cs: assert property (dropDone |-> !respCsAppend)
        else $error("checksum flagged on discarded request");
    chk_resp_sum: assert property (
        respStart && respValid |=>
        {respCsHi, respCsLo} == hx2($past(respChar) & 8'h7F))
        else $error("first response digit pair wrong");
    chk_shed_fire: assert property (
        lastTick |=> shedEvent && !hostMode)
        else $error("no shed at expiry");
    chk_shed_copy: assert property (
        shedEvent |-> localMode == $past(shedModeCfg)
        && localLevel == $past(shedLevelCfg)
        && setpointSel == $past(shedSpCfg))
        else $error("shed settings not taken");
    chk_count_down: assert property (
        midTick |=> shedCount == $past(shedCount) - 8'h01)
        else $error("countdown step wrong");
    chk_shed_off: assert property (!shedLive |=> !shedEvent)
        else $error("shed while disabled");
endmodule // acs_checksum_shed_properties
bind acs_checksum_shed acs_checksum_shed_properties chk_i (.core_clk,
    .reset_n, .rxValid, .rxParityErr, .reqDone, .reqAccept, .reqDiscard,
    .respStart, .respValid, .respCsAppend, .sampleTick, .hostMode,
    .shedEvent, .rxChar, .reqStatHi, .reqStatLo, .respChar, .respCsHi,
    .respCsLo, .shedCount, .shedTimeCfg, .shedLevelCfg, .localLevel,
    .shedModeCfg, .shedSpCfg, .localMode, .setpointSel);
`default_nettype wire

//--- verification/acs_host_model.sv
// Host side model framing request characters onto the stream
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
    input  wire logic       core_clk,
    output var  logic       rxValid,
    output var  logic [7:0] rxChar,
    output var  logic       rxParityErr,
    output var  logic       reqProtected,
    output var  logic       reqHostCtl
);
    logic [7:0] sum;
    logic [7:0] c;
    logic       p;
    // Upper-case hex digit of a nibble
    function automatic logic [7:0] hx(input logic [3:0] n);
        return n + ((n < 4'hA) ? 8'h30 : 8'h37);
    endfunction
    initial begin
        {rxValid, rxChar, rxParityErr, reqProtected, reqHostCtl} = 12'h000;
    end
    // One character per cycle, changed on the falling edge
    task automatic put(input logic [7:0] ch, input logic pe);
        @(negedge core_clk);
        rxValid = 1'b1;
        rxChar = ch;
        rxParityErr = pe;
    endtask
    // Random parity bit so that the device must mask it
    task automatic send(input string s, input logic pr, h, b, e);
        sum = 8'h00;
        for (int i = 0; i < s.len(); i++) begin
            c = s[i];
            p = 1'($urandom);
            put({p, c[6:0]}, e && i == 0);
            sum = sum + {1'b0, c[6:0]};
        end
        if (pr) begin
            sum = sum ^ {7'h00, b}; // A bad field is one bit off
            put(hx(sum[7:4]), 1'b0);
            put(hx(sum[3:0]), 1'b0);
        end
        reqProtected = pr;
        reqHostCtl = h;
        put(8'h0D, 1'b0);
        put(8'h0A, 1'b0);
        @(negedge core_clk);
        rxValid = 1'b0;
        rxChar = ~rxChar; // Idle line never repeats the last value
    endtask
endmodule // acs_host_model
`default_nettype wire

//--- verification/acs_checksum_shed_test.sv
// Self-checking bench for the checksum checker and shed watchdog
`timescale 1ns/1ps
`default_nettype none
module acs_checksum_shed_test;
    logic        core_clk, reset_n, respStart, respValid, sampleTick, shedSeen;
    logic        rxValid, rxParityErr, reqProtected, reqHostCtl, reqDone;
    logic        reqAccept, reqDiscard, respCsAppend, hostMode, shedEvent;
    logic [7:0]  rxChar, reqStatHi, reqStatLo, devStatHi, devStatLo, respChar;
    logic [7:0]  respCsHi, respCsLo, shedTimeCfg, shedLevelCfg, localLevel;
    logic [7:0]  shedCount, sum, expHi, expLo;
    logic [2:0]  devFaultCode;
    logic [1:0]  shedModeCfg, shedSpCfg, localMode, setpointSel;
    logic [13:0] sx;
    logic [33:0] q[$];
    int          mismatches, n_tests;
    wire  [33:0] seen = {reqAccept, reqDiscard, reqStatHi, reqStatLo,
                         devStatHi, devStatLo};
    wire  [13:0] shedOut = {hostMode, shedEvent, localMode, localLevel,
                            setpointSel};
    acs_checksum_shed uut (.core_clk, .reset_n, .rxValid, .rxChar,
        .rxParityErr, .reqProtected, .reqHostCtl, .reqDone, .reqAccept,
        .reqDiscard, .reqStatHi, .reqStatLo, .devStatHi, .devStatLo,
        .devFaultCode, .respStart, .respValid, .respChar, .respCsHi,
        .respCsLo, .respCsAppend, .sampleTick, .shedTimeCfg, .shedModeCfg,
        .shedLevelCfg, .shedSpCfg, .hostMode, .shedEvent, .localMode,
        .localLevel, .setpointSel, .shedCount);
    acs_host_model host (.core_clk, .rxValid, .rxChar, .rxParityErr,
        .reqProtected, .reqHostCtl);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [33:0] sv, ev);
        n_tests++;
        if (sv !== ev) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, ev, sv);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Expectation is queued before the request; a stuck verdict ends the run
    task automatic req(input string s, input logic p, h, b, e);
        logic ok;
        ok = !(b || e);
        if (ok) begin
            expHi = shedSeen ? 8'h38 : 8'h30;
            expLo = 8'h30 + devFaultCode;
            shedSeen = 1'b0;
        end
        q.push_back({ok, !ok, 8'h30, ok ? 8'h30 : 8'h34, expHi, expLo});
        host.send(s, p, h, b, e);
        for (int i = 0; i < 50 && q.size() > 0; i++) @(negedge core_clk);
        if (q.size() > 0) begin
            chk("verdict wait", 0, 1);
            summarize();
        end
        chk("append", respCsAppend, p && ok);
    endtask
    task automatic resp(input int n);
        sum = 8'h00;
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            respStart = (i == 0);
            respValid = 1'b1;
            respChar = 8'($urandom); // Parity bit random; must be masked
            sum = sum + (respChar & 8'h7F);
        end
        @(negedge core_clk);
        {respStart, respValid} = 2'b00;
        chk("resp", {respCsHi, respCsLo},
            {host.hx(sum[7:4]), host.hx(sum[3:0])});
    endtask
    task automatic tick;
        @(negedge core_clk);
        sampleTick = 1'b1;
        @(negedge core_clk);
        sampleTick = 1'b0;
    endtask
    // Verdict watcher takes the oldest note at each reply
    always @(negedge core_clk) begin
        if (reqDone === 1'b1 && q.size() == 0) chk("spare", 1, 0);
        else if (reqDone === 1'b1)
            chk("reply", seen, q.pop_front());
    end
    initial begin
        {reset_n, respStart, respValid, respChar, sampleTick} = 12'h000;
        {devFaultCode, shedTimeCfg, shedModeCfg, shedLevelCfg} = 21'h0;
        {shedSpCfg, shedSeen, expHi, expLo} = {3'h0, 16'h3030};
        void'($urandom(32'hBCDF));
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        req("03,4204,E4,18,001,", 1, 0, 0, 0);
        chk("example", host.sum, 8'h7C);
        req("03,4204,E4,18,001,", 1, 0, 1, 0);
        req("03,4204,E4,18,001,", 1, 0, 0, 0);
        req("03,0204,E8,", 0, 0, 0, 1);
        for (int f = 0; f < 8; f++) begin
            devFaultCode = 3'(f);
            req("09,4204,E8,", f[0], 0, 0, 0);
        end
        $display("test checksum done");
        resp(9);
        resp(1);
        $display("test response done");
        {shedTimeCfg, shedModeCfg, shedLevelCfg, shedSpCfg} =
            {8'h02, 12'($urandom)};
        sx = {2'b01, shedModeCfg, shedLevelCfg, shedSpCfg};
        req("01,4204,E4,", 1, 1, 0, 0);
        chk("load", {hostMode, shedCount}, 9'h102);
        tick();
        chk("down", {hostMode, shedCount}, 9'h101);
        tick();
        chk("shed", shedOut, sx);
        shedSeen = 1'b1;
        req("01,0204,E4,", 0, 0, 0, 0);
        req("01,0204,E4,", 0, 0, 0, 0);
        shedTimeCfg = 8'hFF;
        req("01,4204,E4,", 1, 1, 0, 0);
        chk("clamp", shedCount, 8'hF9);
        repeat (3) tick();
        chk("down3", shedCount, 8'hF6);
        req("01,4204,E4,", 1, 1, 0, 0);
        chk("reload", shedCount, 8'hF9);
        shedTimeCfg = 8'h00;
        req("01,4204,E4,", 1, 1, 0, 0);
        repeat (4) tick();
        chk("no shed", {hostMode, shedCount}, 9'h100);
        $display("test shed done");
        summarize();
    end
endmodule // acs_checksum_shed_test
`default_nettype wire
